// >>> logic/epi_pkg.sv
// Package: register map, fields, codes and timing for the pin interrupts
package epi_pkg;
  // ==========================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CTRL_EXT = 12'h004;
  localparam logic [11:0] OFS_MASK = 12'h008;
  localparam logic [11:0] OFS_PEND = 12'h00c;
  // ==========================================================
  // Field positions
  localparam int SENSE_A_LO = 0;
  localparam int SENSE_B_LO = 2;
  localparam int SENSE_C_SEL = 0;
  localparam int BIT_PIN_B = 7;
  localparam int BIT_PIN_A = 6;
  localparam int BIT_PIN_C = 5;
  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_EXT_RST = 8'h00;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [2:0] PEND_RST = 3'h0;
  localparam logic PIN_IDLE = 1'b1;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WDT_PERIOD_NS = 1000;
  localparam int WDT_CYC = WDT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LVL_SAMPLES = 2;
  localparam int STARTUP_NS = 4000;
  localparam int STARTUP_CYC =
    (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    epi_sense_low = 2'b00,
    epi_sense_any = 2'b01,
    epi_sense_fall = 2'b10,
    epi_sense_rise = 2'b11
  } epi_sense_t;
  typedef enum logic [1:0] {epi_st_run, epi_st_deep, epi_st_startup}
    epi_state_t;
endpackage

// >>> logic/epi_det_if.sv
// Interface: one pin's link between the controller and its detector
`timescale 1ns/1ps
`default_nettype none
interface epi_det_if;
  import epi_pkg::*;
  logic pin;
  logic sample_en;
  epi_sense_t sense;
  logic hit_edge;
  logic hit_low;
  modport det (input pin, input sample_en, input sense,
    output hit_edge, output hit_low);
  modport ctl (output pin, output sample_en, output sense,
    input hit_edge, input hit_low);
endinterface
`default_nettype wire

// >>> logic/epi_edge_det.sv
// Module: per-pin edge and low-level detector
`timescale 1ns/1ps
`default_nettype none
module epi_edge_det #(
  parameter bit LEVEL_OK = 1'b1
) (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronised reset, active low
  epi_det_if.det port // Pin, mode and hits
);
  import epi_pkg::*;
  logic prev_q;
  logic prev_d;
  logic edge_raw;

  // ==========================================================
  // Sampled pin history
  always_comb
  begin
    // Holding the old sample while stopped lets a net change show as an edge on restart
    prev_d = port.sample_en ? port.pin : prev_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_q <= PIN_IDLE;
    else
      prev_q <= prev_d;
  end

  // ==========================================================
  // Edge and level decode
  always_comb
  begin
    case (port.sense)
      epi_sense_low: edge_raw = 1'b0;
      epi_sense_any: edge_raw = port.pin ^ prev_q;
      epi_sense_fall: edge_raw = prev_q & ~port.pin;
      epi_sense_rise: edge_raw = ~prev_q & port.pin;
      default: edge_raw = 1'b0;
    endcase
  end

  // Pin level is read whatever drives it, own output included
  assign port.hit_edge = port.sample_en & edge_raw;
  assign port.hit_low = LEVEL_OK && (port.sense == epi_sense_low)
    && !port.pin;
endmodule
`default_nettype wire

// >>> logic/epi_top.sv
// Module: external pin interrupt controller with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module epi_top
  import epi_pkg::*;
#(
  parameter int STARTUP_CYC_P = epi_pkg::STARTUP_CYC
) (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic nrst, // Async reset, active low
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, OKAY
  output logic [31:0] hrdata, // AHB read data
  input wire logic ext_irq_pin_a, // Interrupt pin a
  input wire logic ext_irq_pin_b, // Interrupt pin b
  input wire logic ext_irq_pin_c, // Interrupt pin c, edge only
  input wire logic global_irq_en, // Core global enable bit
  input wire logic [2:0] irq_ack, // Handler entry, {c,b,a}
  input wire logic sleep_enter, // Core enters sleep, pulse
  input wire logic sleep_idle, // Sleep mode is idle
  output logic [2:0] irq_req, // Requests to core, {c,b,a}
  output logic io_clk_run, // I/O clock running
  output logic wake, // Wake done pulse
  output logic irq // Unmasked pending summary
);
  import epi_pkg::*;

  localparam int SU_W = $clog2(STARTUP_CYC_P + 1);
  localparam int WD_W = $clog2(WDT_CYC + 1);

  logic rst_meta_q;
  logic rst_n_q;
  logic addr_ph;
  logic wr_pend_q;
  logic wr_pend_d;
  logic [11:0] wr_addr_q;
  logic [11:0] wr_addr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0] rd_val;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] ctrl_ext_q;
  logic [7:0] ctrl_ext_d;
  logic [2:0] mask_q;
  logic [2:0] mask_d;
  logic [2:0] pend_q;
  logic [2:0] pend_d;
  logic [2:0] clr;
  logic [2:0] pins;
  logic [2:0] hit_edge;
  logic [2:0] hit_low;
  logic [2:0] lvl_req;
  logic [1:0] lvl_mode;
  epi_state_t st_q;
  epi_state_t st_d;
  logic [WD_W-1:0] wd_cnt_q;
  logic [WD_W-1:0] wd_cnt_d;
  logic [1:0] samp_q;
  logic [1:0] samp_d;
  logic [SU_W-1:0] su_cnt_q;
  logic [SU_W-1:0] su_cnt_d;
  logic wake_q;
  logic wake_d;
  logic deep_lvl;
  logic wd_tick;

  // ==========================================================
  // Reset release
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // Pin detectors
  assign pins = {ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a};
  // Deep sleep halts the I/O clock; idle keeps it
  assign io_clk_run = (st_q == epi_st_run);

  epi_det_if det_if[3] ();

  for (genvar g = 0; g < 3; g++)
  begin : g_det
    assign det_if[g].pin = pins[g];
    if (g < 2)
    begin : g_ab
      // Edges on a and b only with the I/O clock
      assign det_if[g].sample_en = io_clk_run;
      assign det_if[g].sense = epi_sense_t'(ctrl_q[2*g +: 2]);
    end
    else
    begin : g_c
      // Pin c is always watched and can only pick an edge
      assign det_if[g].sample_en = 1'b1;
      assign det_if[g].sense =
        epi_sense_t'({1'b1, ctrl_ext_q[SENSE_C_SEL]});
    end
    assign hit_edge[g] = det_if[g].hit_edge;
    assign hit_low[g] = det_if[g].hit_low;
    epi_edge_det #(
      .LEVEL_OK(g < 2)
    ) u_det (
      .clk(ref_clk),
      .rst_n(rst_n_q),
      .port(det_if[g])
    );
  end

  assign lvl_mode = {ctrl_q[SENSE_B_LO +: 2] == epi_sense_low,
    ctrl_q[SENSE_A_LO +: 2] == epi_sense_low};
  // Level requests held off until wake completes
  assign lvl_req = {1'b0, hit_low[1:0]} & {3{io_clk_run}};
  assign irq_req = {3{global_irq_en}} & mask_q
    & (pend_q | lvl_req);
  assign irq = |(pend_q & mask_q);

  // ==========================================================
  // AHB-Lite slave, zero wait states
  assign addr_ph = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always_comb
  begin
    case (haddr[11:0])
      OFS_CTRL: rd_val = ctrl_q;
      OFS_CTRL_EXT: rd_val = ctrl_ext_q;
      OFS_MASK: rd_val = {mask_q[1], mask_q[0], mask_q[2], 5'h00};
      OFS_PEND: rd_val = {pend_q[1], pend_q[0], pend_q[2], 5'h00};
      default: rd_val = 8'h00;
    endcase
    wr_pend_d = addr_ph & hwrite;
    wr_addr_d = addr_ph ? haddr[11:0] : wr_addr_q;
    rdata_d = (addr_ph && !hwrite) ? {24'h000000, rd_val} : rdata_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Registers and pending flags
  always_comb
  begin
    ctrl_d = ctrl_q;
    ctrl_ext_d = ctrl_ext_q;
    mask_d = mask_q;
    clr = irq_ack;
    if (wr_pend_q)
    begin
      case (wr_addr_q)
        OFS_CTRL: ctrl_d = hwdata[7:0];
        OFS_CTRL_EXT: ctrl_ext_d = hwdata[7:0];
        OFS_MASK: mask_d = {hwdata[BIT_PIN_C], hwdata[BIT_PIN_B],
          hwdata[BIT_PIN_A]};
        OFS_PEND: clr = irq_ack | {hwdata[BIT_PIN_C], hwdata[BIT_PIN_B],
          hwdata[BIT_PIN_A]};
        default: ctrl_d = ctrl_q;
      endcase
    end
    // A new edge wins over a clear in the same cycle
    pend_d = hit_edge | (pend_q & ~clr);
    pend_d[1:0] = pend_d[1:0] & ~lvl_mode;
  end

  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ctrl_q <= CTRL_RST;
      ctrl_ext_q <= CTRL_EXT_RST;
      mask_q <= MASK_RST;
      pend_q <= PEND_RST;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ctrl_ext_q <= ctrl_ext_d;
      mask_q <= mask_d;
      pend_q <= pend_d;
    end
  end

  // ==========================================================
  // Sleep and wake sequencer
  assign deep_lvl = global_irq_en & |(hit_low[1:0] & mask_q[1:0]);
  assign wd_tick = (wd_cnt_q == WD_W'(WDT_CYC - 1));
  assign wake = wake_q;

  always_comb
  begin
    st_d = st_q;
    wd_cnt_d = wd_cnt_q;
    samp_d = samp_q;
    su_cnt_d = su_cnt_q;
    wake_d = 1'b0;
    case (st_q)
      epi_st_run:
      begin
        if (sleep_enter && !sleep_idle)
        begin
          st_d = epi_st_deep;
          wd_cnt_d = '0;
          samp_d = 2'd0;
        end
      end
      epi_st_deep:
      begin
        wd_cnt_d = wd_tick ? '0 : wd_cnt_q + 1'b1;
        // Noise filter: consecutive low samples on the slow tick
        if (wd_tick)
          samp_d = deep_lvl ? samp_q + 2'd1 : 2'd0;
        if ((wd_tick && deep_lvl && samp_q == 2'(LVL_SAMPLES - 1))
            || (pend_d[2] && mask_q[2] && global_irq_en))
        begin
          st_d = epi_st_startup;
          su_cnt_d = SU_W'(STARTUP_CYC_P - 1);
        end
      end
      epi_st_startup:
      begin
        if (su_cnt_q == '0)
        begin
          st_d = epi_st_run;
          wake_d = 1'b1;
        end
        else
          su_cnt_d = su_cnt_q - 1'b1;
      end
      default: st_d = epi_st_run;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      st_q <= epi_st_run;
      wd_cnt_q <= '0;
      samp_q <= 2'd0;
      su_cnt_q <= '0;
      wake_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      wd_cnt_q <= wd_cnt_d;
      samp_q <= samp_d;
      su_cnt_q <= su_cnt_d;
      wake_q <= wake_d;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_q);

  lvl_hold_req_a: assert property (
    (st_q == epi_st_run && lvl_mode[0] && mask_q[0] && global_irq_en
      && !ext_irq_pin_a) |-> irq_req[0])
    else $error("level request a missing while pin low");
  edge_clk_stop_a: assert property (
    (st_q != epi_st_run && !lvl_mode[0] && pend_q[0] == 1'b0)
      |=> !pend_q[0])
    else $error("pin a edge latched with I/O clock stopped");
  req_gating_a: assert property (
    (irq_req != 3'h0) |-> (global_irq_en && (irq_req & ~mask_q) == 3'h0))
    else $error("request without mask and global enable");
  lvl_no_flag_a: assert property (
    lvl_mode[1] |=> !pend_q[1])
    else $error("pending b set in level mode");
  double_sample_a: assert property (
    (st_q == epi_st_deep && wd_tick && deep_lvl && samp_q == 2'd1)
      |=> (st_q == epi_st_startup))
    else $error("wake not started after two low samples");
  startup_end_a: assert property (
    $rose(st_q == epi_st_startup) |-> ##STARTUP_CYC_P wake)
    else $error("wake pulse not at end of start-up time");
  sleep_no_lvl_a: assert property (
    (st_q != epi_st_run) |-> (irq_req[1:0] & ~pend_q[1:0]) == 2'b00)
    else $error("level request raised before wake completed");
  c_async_wake_a: assert property (
    (st_q == epi_st_deep && hit_edge[2] && mask_q[2] && global_irq_en)
      |=> (pend_q[2] && st_q == epi_st_startup))
    else $error("pin c edge did not wake from deep sleep");
  c_rise_sel_a: assert property (
    (ctrl_ext_q[SENSE_C_SEL] && $rose(ext_irq_pin_c)) |=> pend_q[2])
    else $error("rising edge on pin c not latched");
  any_change_a: assert property (
    (io_clk_run && ctrl_q[1:0] == epi_sense_any
      && ext_irq_pin_a != $past(ext_irq_pin_a)
      && $past(io_clk_run)) |=> pend_q[0])
    else $error("any-change edge on pin a not latched");

  lvl_wake_c: cover property ((st_q == epi_st_deep && samp_q == 2'd1)
    ##[1:300] wake);
  pin_c_wake_c: cover property ((st_q == epi_st_deep) ##1 hit_edge[2]);
  w1c_clear_c: cover property (pend_q[0] ##1 wr_pend_q
    && wr_addr_q == OFS_PEND ##1 !pend_q[0]);
  ack_clear_c: cover property (pend_q[2] && irq_ack[2]);
endmodule
`default_nettype wire

// >>> logic/epi_det_if_unused_placeholder_none.sv
// Intentionally empty companion file: no content
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> verif/epi_pin_model.sv
// Partner model: outside circuitry that drives the three interrupt pins
`timescale 1ns/1ps
`default_nettype none
module epi_pin_model (
  input wire logic ref_clk, // Bench clock
  input wire logic nrst, // Reset, active low
  input wire logic [2:0] level_cmd, // Wanted levels {c,b,a}
  output logic ext_irq_pin_a, // Pin a
  output logic ext_irq_pin_b, // Pin b
  output logic ext_irq_pin_c // Pin c
);
  import epi_pkg::*;
  // ==========================================================
  // Pin drivers
  // Levels change just after an edge and stay until commanded again,
  // so a level wanted after wake is held through start-up
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_irq_pin_a <= PIN_IDLE;
      ext_irq_pin_b <= PIN_IDLE;
      ext_irq_pin_c <= PIN_IDLE;
    end
    else
    begin
      ext_irq_pin_a <= level_cmd[0];
      ext_irq_pin_b <= level_cmd[1];
      ext_irq_pin_c <= level_cmd[2];
    end
  end
endmodule
`default_nettype wire

// >>> verif/test_external_pin_interrupts.sv
// Testbench: pin interrupt controller over AHB-Lite with a pin model
`timescale 1ns/1ps
`default_nettype none
module test_external_pin_interrupts;
  import epi_pkg::*;
  // Long enough to drop a level inside start-up
  localparam int SU_CYC = 40;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic pin_a;
  logic pin_b;
  logic pin_c;
  logic [2:0] level_cmd = 3'h7;
  logic global_irq_en = 1'b0;
  logic [2:0] irq_ack = 3'h0;
  logic sleep_enter = 1'b0;
  logic sleep_idle = 1'b0;
  logic [2:0] irq_req;
  logic io_clk_run;
  logic wake;
  logic irq;
  logic [31:0] rd;
  int num_errors = 0;
  int checks_done = 0;

  always #20 ref_clk = ~ref_clk;

  epi_top #(.STARTUP_CYC_P(SU_CYC)) u_epi_top (.ref_clk(ref_clk),
    .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .ext_irq_pin_c(pin_c),
    .global_irq_en(global_irq_en), .irq_ack(irq_ack),
    .sleep_enter(sleep_enter), .sleep_idle(sleep_idle), .irq_req(irq_req),
    .io_clk_run(io_clk_run), .wake(wake), .irq(irq));
  epi_pin_model u_epi_pin_model (.ref_clk(ref_clk), .nrst(nrst),
    .level_cmd(level_cmd), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
    .ext_irq_pin_c(pin_c));

  // ==========================================================
  // Shared helpers
  task automatic print_verdict;
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string msg);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1)
    begin
      num_errors++;
      $display("mismatch at %0t: ready timeout", $time);
    end
  endtask
  task automatic ahb(input logic wr, input logic [11:0] a,
    input logic [7:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
    input string msg);
    ahb(1'b0, a, 8'h00);
    chk(rd, e, msg);
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask
  task automatic set_pin(input int p, input logic v);
    @(posedge ref_clk);
    level_cmd[p] <= v;
    tick(3);
  endtask
  task automatic enter_sleep(input logic idle);
    @(posedge ref_clk);
    sleep_enter <= 1'b1;
    sleep_idle <= idle;
    @(posedge ref_clk);
    sleep_enter <= 1'b0;
    tick(1);
  endtask
  task automatic wait_wake;
    int n;
    n = 0;
    while (wake !== 1'b1 && n < 400)
    begin
      tick(1);
      n++;
    end
    chk({31'h0, wake}, 32'h1, "wake pulse");
    tick(1);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rchk(OFS_CTRL, 32'h0, "ctrl reset");
    rchk(OFS_PEND, 32'h0, "pending reset");
    wreg(OFS_CTRL, 8'ha5);
    rchk(OFS_CTRL, 32'ha5, "ctrl rw");
    wreg(12'h010, 8'hff);
    rchk(12'h010, 32'h0, "unmapped");
  endtask
  task automatic t_edges;
    logic [7:0] mb;
    logic ef;
    logic er;
    global_irq_en <= 1'b1;
    for (int p = 0; p < 2; p++)
      for (int c = 1; c < 4; c++)
      begin
        mb = (p == 0) ? 8'h40 : 8'h80;
        ef = (c != 3);
        er = (c != 2);
        wreg(OFS_CTRL, 8'(c << (2 * p)));
        wreg(OFS_MASK, mb);
        wreg(OFS_PEND, 8'he0);
        set_pin(p, 1'b0);
        chk({29'h0, irq_req}, ef ? (32'h1 << p) : 32'h0, "fall req");
        rchk(OFS_PEND, ef ? {24'h0, mb} : 32'h0, "fall flag");
        @(posedge ref_clk);
        irq_ack[p] <= 1'b1;
        @(posedge ref_clk);
        irq_ack[p] <= 1'b0;
        rchk(OFS_PEND, 32'h0, "ack clears");
        set_pin(p, 1'b1);
        rchk(OFS_PEND, er ? {24'h0, mb} : 32'h0, "rise flag");
      end
  endtask
  task automatic t_level;
    wreg(OFS_CTRL, 8'h00);
    wreg(OFS_MASK, 8'h40);
    set_pin(0, 1'b0);
    tick(5);
    chk({29'h0, irq_req}, 32'h1, "level held");
    rchk(OFS_PEND, 32'h0, "level flag");
    @(posedge ref_clk);
    global_irq_en <= 1'b0;
    tick(1);
    chk({29'h0, irq_req}, 32'h0, "global gate");
    @(posedge ref_clk);
    global_irq_en <= 1'b1;
    set_pin(0, 1'b1);
    chk({29'h0, irq_req}, 32'h0, "level gone");
  endtask
  task automatic t_pin_c;
    wreg(OFS_CTRL_EXT, 8'h00);
    wreg(OFS_MASK, 8'h20);
    wreg(OFS_PEND, 8'he0);
    global_irq_en <= 1'b0;
    set_pin(2, 1'b0);
    chk({29'h0, irq_req}, 32'h0, "no global");
    chk({31'h0, irq}, 32'h1, "summary");
    @(posedge ref_clk);
    global_irq_en <= 1'b1;
    tick(1);
    chk({29'h0, irq_req}, 32'h4, "pin c fall");
    wreg(OFS_CTRL_EXT, 8'h01);
    wreg(OFS_PEND, 8'he0);
    set_pin(2, 1'b1);
    rchk(OFS_PEND, 32'h20, "pin c rise");
    wreg(OFS_MASK, 8'h00);
    tick(1);
    chk({31'h0, irq}, 32'h0, "masked");
    wreg(OFS_PEND, 8'he0);
  endtask
  task automatic t_sleep_level(input logic hold);
    wreg(OFS_CTRL, 8'h08);
    wreg(OFS_MASK, 8'h40);
    wreg(OFS_PEND, 8'he0);
    enter_sleep(1'b0);
    chk({31'h0, io_clk_run}, 32'h0, "clock stops");
    set_pin(1, 1'b0);
    set_pin(0, 1'b0);
    set_pin(1, 1'b1);
    if (!hold)
    begin
      tick(54);
      @(posedge ref_clk);
      level_cmd[0] <= 1'b1;
    end
    wait_wake();
    chk({31'h0, io_clk_run}, 32'h1, "clock back");
    chk({31'h0, irq_req[0]}, {31'h0, hold}, "req after wake");
    rchk(OFS_PEND, 32'h0, "b unseen");
    set_pin(0, 1'b1);
  endtask
  task automatic t_sleep_c;
    enter_sleep(1'b1);
    tick(2);
    chk({31'h0, io_clk_run}, 32'h1, "idle runs");
    wreg(OFS_CTRL_EXT, 8'h00);
    wreg(OFS_MASK, 8'h20);
    wreg(OFS_PEND, 8'he0);
    wreg(OFS_CTRL, 8'h0a);
    enter_sleep(1'b0);
    set_pin(0, 1'b0);
    set_pin(0, 1'b1);
    set_pin(2, 1'b0);
    wait_wake();
    rchk(OFS_PEND, 32'h20, "c wakes, a unseen");
    @(posedge ref_clk);
    irq_ack[2] <= 1'b1;
    @(posedge ref_clk);
    irq_ack[2] <= 1'b0;
    rchk(OFS_PEND, 32'h0, "ack clears c");
    set_pin(2, 1'b1);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    tick(4);
    t_regs();
    t_edges();
    t_level();
    t_pin_c();
    t_sleep_level(1'b1);
    t_sleep_level(1'b0);
    t_sleep_c();
    print_verdict();
  end
  initial
  begin
    #800000;
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
